// ===== spc_port_ctrl.sv
// Ethernet switch port configuration, flow control and status logic
`timescale 1ns/100ps
`include "spc_regs.svh"

module spc_port_ctrl (
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [31:0]         reg_rdata,
  input  wire logic           port_is_fiber,
  input  wire logic           phy_link_up,
  input  wire logic           neg_done,
  input  wire spc_pkg::spc_speed_t neg_speed,
  input  wire logic           neg_full,
  input  wire logic           partner_pause,
  input  wire logic           rx_frame_end,
  input  wire logic [13:0]    rx_frame_len,
  input  wire logic           tx_frame_start,
  input  wire logic           tx_collision,
  output logic                port_enable,
  output logic                an_enable,
  output logic                an_restart,
  output logic                an_adv_pause,
  output logic                rx_pause_en,
  output logic                tx_pause_en,
  output logic                auto_crossover_detect,
  output logic                link_down_power_save,
  output logic                link_up_power_save,
  output logic                rx_drop,
  output logic                tx_discard,
  output logic                tx_backoff_restart,
  output spc_pkg::spc_speed_t cur_speed,
  output logic                cur_full,
  output logic [6:0]          power_pct,
  output logic                irq
);
  import spc_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Mode uses negotiation
  function automatic logic is_neg(input spc_mode_t m);
    is_neg = (m == SPC_AUTO) || (m == SPC_FIB_NEG_1G) ||
             (m == SPC_FIB_NEG_10G);
  endfunction

  // Speed of a forced mode
  function automatic spc_speed_t forced_speed(input spc_mode_t m);
    case (m)
      SPC_F10M_HALF, SPC_F10M_FULL:   forced_speed = SPC_SPD_10M;
      SPC_F100M_HALF, SPC_F100M_FULL: forced_speed = SPC_SPD_100M;
      SPC_F1G_FULL:                   forced_speed = SPC_SPD_1G;
      SPC_F10G_FULL:                  forced_speed = SPC_SPD_10G;
      default:                        forced_speed = SPC_SPD_DOWN;
    endcase
  endfunction

  // Power base figure for a running speed
  function automatic logic [6:0] speed_power(input spc_speed_t s);
    case (s)
      SPC_SPD_10M:  speed_power = `SPC_PWR_10M;
      SPC_SPD_100M: speed_power = `SPC_PWR_100M;
      SPC_SPD_1G:   speed_power = `SPC_PWR_1G;
      SPC_SPD_10G:  speed_power = `SPC_PWR_10G;
      default:      speed_power = `SPC_PWR_DOWN;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  spc_state_t  st_reg;        // Registered state
  spc_state_t  st_next;       // Next state
  logic        wr_cfg;        // Write to configuration word
  logic        wr_commit;     // Commit strobe
  logic        changed;       // Committed speed or pause differs
  logic        forced;        // Committed mode is a forced one or disabled
  logic        link_now;      // Link is really up
  logic        oversize;      // Frame longer than the limit
  logic        coll_hit;      // Collision count reaches limit
  logic [13:0] len_cap;       // Port type length ceiling
  logic [13:0] len_req;       // Requested length clamped
  logic [3:0]  events;        // Event pulses this cycle
  logic [31:0] status_word;   // Assembled status
  logic [6:0]  pwr;           // Power figure after save cut, before port disable gating

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Builds the whole next state
  always_comb begin
    st_next   = st_reg;
    wr_cfg    = reg_wr && (reg_addr == `SPC_OFS_CFG);
    wr_commit = reg_wr && (reg_addr == `SPC_OFS_COMMIT) && reg_wdata[0];
    // Length ceiling follows port medium
    len_cap = port_is_fiber ? `SPC_LEN_FIBER : `SPC_LEN_COPPER;
    len_req = st_reg.cfg_maxlen;
    if (len_req < `SPC_LEN_MIN) begin
      len_req = `SPC_LEN_MIN;
    end else if (len_req > len_cap) begin
      len_req = len_cap;
    end
    // Configuration and length writes only touch the shadow copy
    if (wr_cfg) begin
      st_next.cfg_mode = spc_mode_t'(reg_wdata[`SPC_CFG_MODE_LSB +: 4]);
      st_next.cfg_fc   = reg_wdata[`SPC_CFG_FC_BIT];
      st_next.cfg_exc  = reg_wdata[`SPC_CFG_EXC_BIT];
      st_next.cfg_ps   = spc_ps_t'(reg_wdata[`SPC_CFG_PS_LSB +: 2]);
    end
    if (reg_wr && (reg_addr == `SPC_OFS_MAXLEN)) begin
      st_next.cfg_maxlen = reg_wdata[13:0];
    end
    if (reg_wr && (reg_addr == `SPC_OFS_INT_MASK)) begin
      st_next.int_mask = reg_wdata[3:0];
    end
    // Commit copies shadow into the active set
    changed = (st_reg.cfg_mode != st_reg.act_mode) ||
              (st_reg.cfg_fc != st_reg.act_fc);
    if (wr_commit) begin
      st_next.act_mode   = st_reg.cfg_mode;
      st_next.act_fc     = st_reg.cfg_fc;
      st_next.act_exc    = st_reg.cfg_exc;
      st_next.act_ps     = st_reg.cfg_ps;
      st_next.act_maxlen = len_req;
    end
    forced = !is_neg(st_next.act_mode);
    // Negotiation controller
    st_next.an_restart = 1'b0;
    case (st_reg.neg)
      SPC_NEG_OFF: begin
        if (!forced) begin
          st_next.neg = SPC_NEG_RESTART;
        end
      end
      SPC_NEG_RESTART: begin
        st_next.an_restart = 1'b1;
        st_next.neg        = SPC_NEG_WAIT;
      end
      SPC_NEG_WAIT: begin
        if (neg_done) begin
          st_next.neg       = SPC_NEG_DONE;
          st_next.neg_speed = neg_speed;
          st_next.neg_full  = neg_full;
          st_next.neg_pause = partner_pause;
        end
      end
      SPC_NEG_DONE: begin
        if (neg_done) begin
          st_next.neg_speed = neg_speed;
          st_next.neg_full  = neg_full;
          st_next.neg_pause = partner_pause;
        end
      end
      default: st_next.neg = SPC_NEG_OFF;
    endcase
    // Change of speed or pause starts a fresh exchange
    if (wr_commit && changed && !forced) begin
      st_next.neg = SPC_NEG_RESTART;
    end
    if (forced) begin
      st_next.neg        = SPC_NEG_OFF;
      st_next.an_restart = 1'b0;
    end
    if (st_next.neg != SPC_NEG_DONE) begin
      st_next.neg_pause = 1'b0;
    end
    // Port controls
    st_next.port_enable  = st_next.act_mode != SPC_DISABLED;
    st_next.an_enable    = !forced;
    st_next.an_adv_pause = !forced && st_next.act_fc;
    link_now = phy_link_up && st_next.port_enable;
    // Operating pause enables
    if (!st_next.port_enable) begin
      st_next.rx_pause = 1'b0;
      st_next.tx_pause = 1'b0;
    end else if (forced) begin
      st_next.rx_pause = st_next.act_fc;
      st_next.tx_pause = st_next.act_fc;
    end else begin
      st_next.rx_pause = st_next.act_fc && st_next.neg_pause;
      st_next.tx_pause = st_next.act_fc && st_next.neg_pause;
    end
    // Crossover off in forced low speed modes
    st_next.xover_en = !((st_next.act_mode == SPC_F10M_HALF) ||
                         (st_next.act_mode == SPC_F10M_FULL) ||
                         (st_next.act_mode == SPC_F100M_HALF) ||
                         (st_next.act_mode == SPC_F100M_FULL));
    // Power saving selector
    st_next.ld_ps = st_next.act_ps[0];
    st_next.lu_ps = st_next.act_ps[1];
    // Current speed and duplex
    st_next.link_q = link_now;
    if (!link_now) begin
      st_next.cur_speed = SPC_SPD_DOWN;
      st_next.cur_full  = 1'b0;
    end else if (forced) begin
      st_next.cur_speed = forced_speed(st_next.act_mode);
      st_next.cur_full  = (st_next.act_mode != SPC_F10M_HALF) &&
                          (st_next.act_mode != SPC_F100M_HALF);
    end else begin
      st_next.cur_speed = st_next.neg_speed;
      st_next.cur_full  = st_next.neg_full;
    end
    // Power usage figure
    pwr = speed_power(st_next.cur_speed);
    if (!link_now) begin
      pwr = st_next.ld_ps ? `SPC_PWR_DOWN_PS : `SPC_PWR_DOWN;
    end else if (st_next.lu_ps) begin
      pwr = pwr - `SPC_PWR_UP_CUT;
    end
    st_next.pwr_pct = st_next.port_enable ? pwr : 7'h00;
    // Oversize receive frames are dropped and counted
    oversize = rx_frame_end && (rx_frame_len > st_reg.act_maxlen);
    st_next.rx_drop = oversize;
    if (oversize && (st_reg.err_cnt != 16'hFFFF)) begin
      st_next.err_cnt = st_reg.err_cnt + 16'h0001;
    end
    // Collision counting and excessive-collision policy
    st_next.tx_discard = 1'b0;
    st_next.tx_restart = 1'b0;
    coll_hit = tx_collision && !tx_frame_start &&
               (st_reg.coll_cnt == (`SPC_COLL_LIMIT - 5'h01));
    if (tx_frame_start) begin
      st_next.coll_cnt = 5'h00;
    end else if (coll_hit) begin
      st_next.coll_cnt   = 5'h00;
      st_next.tx_discard = !st_reg.act_exc;
      st_next.tx_restart = st_reg.act_exc;
    end else if (tx_collision) begin
      st_next.coll_cnt = st_reg.coll_cnt + 5'h01;
    end
    // Sticky events, set wins over write-one clear
    events = 4'h0;
    events[`SPC_EV_LINK]     = link_now != st_reg.link_q;
    events[`SPC_EV_OVERSIZE] = oversize;
    events[`SPC_EV_EXCOLL]   = coll_hit;
    events[`SPC_EV_NEGDONE]  = neg_done && (st_reg.neg == SPC_NEG_WAIT);
    if (reg_wr && (reg_addr == `SPC_OFS_INT_STAT)) begin
      st_next.int_stat = st_reg.int_stat & ~reg_wdata[3:0];
    end
    st_next.int_stat = st_next.int_stat | events;
    st_next.irq = |(st_next.int_stat & st_next.int_mask);
    // Read data for the next cycle only
    status_word = 32'h0;
    status_word[`SPC_ST_LINK_BIT]     = st_reg.link_q;
    status_word[`SPC_ST_SPD_LSB +: 3] = st_reg.cur_speed;
    status_word[`SPC_ST_FULL_BIT]     = st_reg.cur_full;
    status_word[`SPC_ST_RXP_BIT]      = st_reg.rx_pause;
    status_word[`SPC_ST_TXP_BIT]      = st_reg.tx_pause;
    status_word[`SPC_ST_XOVR_BIT]     = st_reg.xover_en;
    status_word[`SPC_ST_PWR_LSB +: 7] = st_reg.pwr_pct;
    status_word[`SPC_ST_NEG_LSB +: 2] = st_reg.neg;
    st_next.rd_data = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `SPC_OFS_CFG: begin
          st_next.rd_data[`SPC_CFG_MODE_LSB +: 4] = st_reg.cfg_mode;
          st_next.rd_data[`SPC_CFG_FC_BIT]        = st_reg.cfg_fc;
          st_next.rd_data[`SPC_CFG_EXC_BIT]       = st_reg.cfg_exc;
          st_next.rd_data[`SPC_CFG_PS_LSB +: 2]   = st_reg.cfg_ps;
        end
        `SPC_OFS_MAXLEN:   st_next.rd_data[13:0] = st_reg.act_maxlen;
        `SPC_OFS_STATUS:   st_next.rd_data = status_word;
        `SPC_OFS_INT_STAT: st_next.rd_data[3:0] = st_reg.int_stat;
        `SPC_OFS_INT_MASK: st_next.rd_data[3:0] = st_reg.int_mask;
        `SPC_OFS_RX_ERR:   st_next.rd_data[15:0] = st_reg.err_cnt;
        default:           st_next.rd_data = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Registers the state, synchronous reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg            <= '0;
      st_reg.cfg_mode   <= SPC_AUTO;
      st_reg.act_mode   <= SPC_AUTO;
      st_reg.cfg_maxlen <= `SPC_LEN_MIN;
      st_reg.act_maxlen <= `SPC_LEN_MIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata             = st_reg.rd_data;
  assign port_enable           = st_reg.port_enable;
  assign an_enable             = st_reg.an_enable;
  assign an_restart            = st_reg.an_restart;
  assign an_adv_pause          = st_reg.an_adv_pause;
  assign rx_pause_en           = st_reg.rx_pause;
  assign tx_pause_en           = st_reg.tx_pause;
  assign auto_crossover_detect = st_reg.xover_en;
  assign link_down_power_save  = st_reg.ld_ps;
  assign link_up_power_save    = st_reg.lu_ps;
  assign rx_drop               = st_reg.rx_drop;
  assign tx_discard            = st_reg.tx_discard;
  assign tx_backoff_restart    = st_reg.tx_restart;
  assign cur_speed             = st_reg.cur_speed;
  assign cur_full              = st_reg.cur_full;
  assign power_pct             = st_reg.pwr_pct;
  assign irq                   = st_reg.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_FORCED_NO_NEG: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_reg.act_mode inside {[SPC_F10M_HALF:SPC_F10G_FULL]}) |->
      (!an_enable && !an_restart))
    else $error("forced mode left negotiation running");
  AST_DISABLED_DOWN: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_reg.act_mode == SPC_DISABLED) |->
      (!port_enable && cur_speed == SPC_SPD_DOWN && !rx_pause_en))
    else $error("disabled port still active");
  AST_ADV_PAUSE: assert property (
    @(posedge core_clk) disable iff (reset)
    an_enable |-> (an_adv_pause == st_reg.act_fc))
    else $error("advertised pause differs from setting");
  AST_FORCED_PAUSE: assert property (
    @(posedge core_clk) disable iff (reset)
    (port_enable && !an_enable) |->
      (rx_pause_en == st_reg.act_fc && tx_pause_en == st_reg.act_fc))
    else $error("forced pause not applied");
  AST_NEG_PAUSE: assert property (
    @(posedge core_clk) disable iff (reset)
    (an_enable && st_reg.neg != SPC_NEG_DONE) |-> !rx_pause_en)
    else $error("pause enabled before negotiation result");
  AST_OVERSIZE: assert property (
    @(posedge core_clk) disable iff (reset)
    (rx_frame_end && rx_frame_len > st_reg.act_maxlen) |=> rx_drop)
    else $error("oversize frame not dropped");
  AST_LEN_RANGE: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_reg.act_maxlen >= `SPC_LEN_MIN) &&
      (st_reg.act_maxlen <= `SPC_LEN_COPPER))
    else $error("active frame limit out of range");
  AST_EXCOLL: assert property (
    @(posedge core_clk) disable iff (reset)
    (tx_collision && !tx_frame_start && st_reg.coll_cnt == 5'h0F &&
     !st_reg.act_exc) |=> (tx_discard && !tx_backoff_restart))
    else $error("sixteenth collision did not discard");
  AST_RESTART: assert property (
    @(posedge core_clk) disable iff (reset)
    (tx_collision && !tx_frame_start && st_reg.coll_cnt == 5'h0F &&
     st_reg.act_exc) |=> (tx_backoff_restart && !tx_discard))
    else $error("sixteenth collision did not restart backoff");
  AST_XOVER: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_reg.act_mode inside {[SPC_F10M_HALF:SPC_F100M_FULL]}) |->
      !auto_crossover_detect)
    else $error("crossover detect on in forced low speed");
  AST_RENEG: assert property (
    @(posedge core_clk) disable iff (reset)
    (reg_wr && reg_addr == `SPC_OFS_COMMIT && reg_wdata[0] &&
     is_neg(st_reg.cfg_mode) &&
     (st_reg.cfg_mode != st_reg.act_mode || st_reg.cfg_fc != st_reg.act_fc))
      |=> ##1 an_restart)
    else $error("commit of changed setting did not renegotiate");
endmodule

// ===== spc_regs.svh
// Register offsets, field positions, reset values and limits of the port block
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
// Byte offsets on the register port
`define SPC_OFS_CFG      8'h00
`define SPC_OFS_MAXLEN   8'h04
`define SPC_OFS_COMMIT   8'h08
`define SPC_OFS_STATUS   8'h0C
`define SPC_OFS_INT_STAT 8'h10
`define SPC_OFS_INT_MASK 8'h14
`define SPC_OFS_RX_ERR   8'h18
// Configuration word fields
`define SPC_CFG_MODE_LSB 0
`define SPC_CFG_FC_BIT   4
`define SPC_CFG_EXC_BIT  5
`define SPC_CFG_PS_LSB   6
// Status word fields
`define SPC_ST_LINK_BIT  0
`define SPC_ST_SPD_LSB   1
`define SPC_ST_FULL_BIT  4
`define SPC_ST_RXP_BIT   5
`define SPC_ST_TXP_BIT   6
`define SPC_ST_XOVR_BIT  7
`define SPC_ST_PWR_LSB   8
`define SPC_ST_NEG_LSB   16
// Interrupt bit positions
`define SPC_EV_LINK      0
`define SPC_EV_OVERSIZE  1
`define SPC_EV_EXCOLL    2
`define SPC_EV_NEGDONE   3
// Frame length limits in bytes
`define SPC_LEN_MIN      14'h05EE
`define SPC_LEN_COPPER   14'h2580
`define SPC_LEN_FIBER    14'h2328
// Collisions before the excessive-collision policy acts
`define SPC_COLL_LIMIT   5'h10
// Power usage figures in percent
`define SPC_PWR_DOWN     7'h28
`define SPC_PWR_DOWN_PS  7'h0A
`define SPC_PWR_UP_CUT   7'h14
`define SPC_PWR_10M      7'h1E
`define SPC_PWR_100M     7'h32
`define SPC_PWR_1G       7'h50
`define SPC_PWR_10G      7'h64
`endif

// ===== spc_pkg.sv
// Types shared by the port configuration block
package spc_pkg;
  // Configured link speed selections
  typedef enum logic [3:0] {
    SPC_DISABLED   = 4'h0,
    SPC_AUTO       = 4'h1,
    SPC_F10M_HALF  = 4'h2,
    SPC_F10M_FULL  = 4'h3,
    SPC_F100M_HALF = 4'h4,
    SPC_F100M_FULL = 4'h5,
    SPC_F1G_FULL   = 4'h6,
    SPC_F10G_FULL  = 4'h7,
    SPC_FIB_NEG_1G = 4'h8,
    SPC_FIB_NEG_10G = 4'h9
  } spc_mode_t;
  // Current link speed report
  typedef enum logic [2:0] {
    SPC_SPD_DOWN = 3'h0,
    SPC_SPD_10M  = 3'h1,
    SPC_SPD_100M = 3'h2,
    SPC_SPD_1G   = 3'h3,
    SPC_SPD_10G  = 3'h4
  } spc_speed_t;
  // Power saving selector
  typedef enum logic [1:0] {
    SPC_PS_OFF  = 2'h0,
    SPC_PS_DOWN = 2'h1,
    SPC_PS_UP   = 2'h2,
    SPC_PS_BOTH = 2'h3
  } spc_ps_t;
  // Negotiation control states
  typedef enum logic [1:0] {
    SPC_NEG_OFF     = 2'h0,
    SPC_NEG_RESTART = 2'h1,
    SPC_NEG_WAIT    = 2'h2,
    SPC_NEG_DONE    = 2'h3
  } spc_neg_t;
  // Whole state of the block
  typedef struct packed {
    spc_mode_t   cfg_mode;
    logic        cfg_fc;
    logic        cfg_exc;
    spc_ps_t     cfg_ps;
    logic [13:0] cfg_maxlen;
    spc_mode_t   act_mode;
    logic        act_fc;
    logic        act_exc;
    spc_ps_t     act_ps;
    logic [13:0] act_maxlen;
    spc_neg_t    neg;
    spc_speed_t  neg_speed;
    logic        neg_full;
    logic        neg_pause;
    logic [4:0]  coll_cnt;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [15:0] err_cnt;
    logic        link_q;
    logic [31:0] rd_data;
    logic        port_enable;
    logic        an_enable;
    logic        an_restart;
    logic        an_adv_pause;
    logic        rx_pause;
    logic        tx_pause;
    logic        xover_en;
    logic        ld_ps;
    logic        lu_ps;
    logic        rx_drop;
    logic        tx_discard;
    logic        tx_restart;
    logic        irq;
    spc_speed_t  cur_speed;
    logic        cur_full;
    logic [6:0]  pwr_pct;
  } spc_state_t;
endpackage

// ===== spc_link_partner.sv
// Behavioural link partner answering negotiation restarts
`timescale 1ns/100ps
module spc_link_partner (
  input  wire logic           core_clk,
  input  wire logic           an_restart,
  input  wire logic           pause_cap,
  input  wire logic           slow,
  output logic                neg_done,
  output spc_pkg::spc_speed_t neg_speed,
  output logic                neg_full,
  output logic                partner_pause
);
  import spc_pkg::*;
  int cnt = -1; // Cycles left before the answer
  initial begin
    neg_done = 1'b0;
    neg_speed = SPC_SPD_DOWN;
    neg_full = 1'b0;
    partner_pause = 1'b0;
  end
  // Speed, duplex and pause lines toggle outside the one-cycle answer; neg_done stays low
  always @(posedge core_clk) begin
    neg_done <= 1'b0;
    neg_speed <= spc_speed_t'(~neg_speed);
    neg_full <= ~neg_full;
    partner_pause <= ~partner_pause;
    if (an_restart)
      cnt <= slow ? 20 : 2;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0) begin
      // Exchange outcome with the partner pause wish
      neg_done <= 1'b1;
      neg_speed <= slow ? SPC_SPD_10G : SPC_SPD_1G;
      neg_full <= 1'b1;
      partner_pause <= pause_cap;
      cnt <= -1;
    end
  end
endmodule

// ===== spc_port_ctrl_tb_top.sv
// Self-checking bench for the port configuration block
`timescale 1ns/100ps
`include "spc_regs.svh"
module spc_port_ctrl_tb_top;
  import spc_pkg::*;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic port_is_fiber = 0, phy_link_up = 1, rx_frame_end = 0;
  logic [13:0] rx_frame_len = 0;
  logic tx_frame_start = 0, tx_collision = 0, pause_cap = 0, slow = 0;
  logic neg_done, neg_full, partner_pause, port_enable, an_enable;
  logic an_restart, an_adv_pause, rx_pause_en, tx_pause_en;
  logic auto_crossover_detect, link_down_power_save, link_up_power_save;
  logic rx_drop, tx_discard, tx_backoff_restart, cur_full, irq, fc;
  logic [6:0] power_pct, pw;
  spc_speed_t neg_speed, cur_speed, sp;
  spc_mode_t md;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int mismatches = 0, tests_run = 0, cyc = 0;
  initial forever #50 core_clk = ~core_clk;
  spc_port_ctrl u_dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_is_fiber, .phy_link_up, .neg_done,
    .neg_speed, .neg_full, .partner_pause, .rx_frame_end, .rx_frame_len,
    .tx_frame_start, .tx_collision, .port_enable, .an_enable, .an_restart,
    .an_adv_pause, .rx_pause_en, .tx_pause_en, .auto_crossover_detect,
    .link_down_power_save, .link_up_power_save, .rx_drop, .tx_discard,
    .tx_backoff_restart, .cur_speed, .cur_full, .power_pct, .irq);
  spc_link_partner u_lp (.core_clk, .an_restart, .pause_cap, .slow,
    .neg_done, .neg_speed, .neg_full, .partner_pause);
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // Write settings, commit, let outputs settle
  task automatic cfg(spc_mode_t m, logic f, logic x, logic [1:0] p);
    wr(`SPC_OFS_CFG, {24'h0, p, x, f, m});
    wr(`SPC_OFS_COMMIT, 32'h1);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wait_nd();
    int n;
    n = 0;
    while (neg_done !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 100)
      mismatches++;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic frame(input logic [13:0] len, input logic drop);
    @(posedge core_clk);
    rx_frame_end <= 1'b1;
    rx_frame_len <= len;
    @(posedge core_clk);
    rx_frame_end <= 1'b0;
    @(negedge core_clk);
    chk(rx_drop, drop);
  endtask
  task automatic coll(input logic x);
    cfg(SPC_F1G_FULL, 1'b0, x, 2'h0);
    @(posedge core_clk);
    tx_frame_start <= 1'b1;
    repeat (16) begin
      @(posedge core_clk);
      tx_frame_start <= 1'b0;
      tx_collision <= 1'b1;
    end
    @(posedge core_clk);
    tx_collision <= 1'b0;
    @(negedge core_clk);
    chk({tx_discard, tx_backoff_restart}, {~x, x});
  endtask
  // Read results are taken in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_q)
      chk(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h7d0fe59d));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd(`SPC_OFS_MAXLEN, {18'h0, `SPC_LEN_MIN});
    rd(8'h1C, 32'h0);
    // Forced modes, every power-save value on the way
    for (int m = 2; m < 8; m++) begin
      md = spc_mode_t'(m);
      fc = 1'($urandom);
      cfg(md, fc, 1'b0, m[1:0]);
      sp = m < 4 ? SPC_SPD_10M : m < 6 ? SPC_SPD_100M
         : m == 6 ? SPC_SPD_1G : SPC_SPD_10G;
      pw = m < 4 ? `SPC_PWR_10M : m < 6 ? `SPC_PWR_100M
         : m == 6 ? `SPC_PWR_1G : `SPC_PWR_10G;
      chk({port_enable, an_enable, cur_speed}, {2'b10, sp});
      chk(cur_full, m[0] | (m > 5));
      chk({rx_pause_en, tx_pause_en}, {fc, fc});
      chk(auto_crossover_detect, m > 5);
      chk({link_up_power_save, link_down_power_save}, m[1:0]);
      chk(power_pct, pw - (m[1] ? `SPC_PWR_UP_CUT : 7'h0));
    end
    wr(`SPC_OFS_INT_STAT, 32'hF);
    phy_link_up <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(power_pct, `SPC_PWR_DOWN_PS);
    rd(`SPC_OFS_INT_STAT, 32'h1);
    cfg(SPC_DISABLED, 1'b1, 1'b0, 2'h0);
    chk({port_enable, power_pct}, 8'h0);
    @(posedge core_clk) phy_link_up <= 1'b1;
    // Each negotiated selection, partner quick and slow
    for (int i = 0; i < 3; i++) begin
      md = i == 0 ? SPC_AUTO : i == 1 ? SPC_FIB_NEG_1G : SPC_FIB_NEG_10G;
      pause_cap <= i != 1;
      slow <= i[0];
      cfg(md, 1'b1, 1'b0, 2'h0);
      wait_nd();
      chk({an_enable, an_adv_pause}, 2'b11);
      chk({rx_pause_en, tx_pause_en}, {2{i != 1}});
      chk(cur_speed, i[0] ? SPC_SPD_10G : SPC_SPD_1G);
    end
    rd(`SPC_OFS_STATUS, 32'h000350F7);
    wr(`SPC_OFS_INT_STAT, 32'hF);
    wr(`SPC_OFS_INT_MASK, 32'h2);
    wr(`SPC_OFS_MAXLEN, 32'h3FFF);
    wr(`SPC_OFS_COMMIT, 32'h1);
    rd(`SPC_OFS_MAXLEN, {18'h0, `SPC_LEN_COPPER});
    frame(14'($urandom_range(9600, 64)), 1'b0);
    frame(`SPC_LEN_COPPER, 1'b0);
    chk(irq, 1'b0);
    frame(`SPC_LEN_COPPER + 14'h1, 1'b1);
    @(negedge core_clk);
    chk(irq, 1'b1);
    rd(`SPC_OFS_RX_ERR, 32'h1);
    wr(`SPC_OFS_INT_STAT, 32'h2);
    @(negedge core_clk);
    chk(irq, 1'b0);
    @(posedge core_clk) port_is_fiber <= 1'b1;
    wr(`SPC_OFS_COMMIT, 32'h1);
    rd(`SPC_OFS_MAXLEN, {18'h0, `SPC_LEN_FIBER});
    coll(1'b0);
    coll(1'b1);
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule
